// *** sscr_pkg.sv ***
// Shared constants, types and helper functions of the start-up configuration reader.
package sscr_pkg;

	// ----------------------------------------------------------------
	// Configuration word layout
	// ----------------------------------------------------------------
	localparam int CFG_WORD_W = 10;
	localparam int NODE_MSB = 9;
	localparam int NODE_LSB = 3;
	localparam int RATE_MSB = 2;
	localparam int RATE_LSB = 0;
	localparam int NODE_W = NODE_MSB - NODE_LSB + 1;
	localparam int RATE_W = RATE_MSB - RATE_LSB + 1;
	localparam logic [NODE_W-1:0] NODE_ILLEGAL = 7'h00;
	localparam logic [CFG_WORD_W-1:0] WORD_RECOVERY = 10'h3FF;
	localparam int KBPS_W = 10;
	localparam logic [3:0] BIT_CNT_W = 4'hA;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_NS = 5;
	localparam int SHIFT_CLK_PERIOD_NS = 1200;
	localparam int SHIFT_HALF_CYC = (SHIFT_CLK_PERIOD_NS / 2 + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int SPI_CLK_PERIOD_NS = 1000;
	localparam int SPI_HALF_CYC = (SPI_CLK_PERIOD_NS / 2 + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int DIV_W = 16;

	// ----------------------------------------------------------------
	// Converter links
	// ----------------------------------------------------------------
	localparam int SPI_W = 24;
	localparam int FLEN_W = 5;
	localparam logic [FLEN_W-1:0] FLEN_SHORT = 5'h10;
	localparam logic [FLEN_W-1:0] FLEN_LONG = 5'h18;
	localparam logic [1:0] CONV_TYPE_A = 2'h0;
	localparam logic [1:0] CONV_TYPE_B = 2'h1;
	localparam logic [1:0] CONV_TYPE_C = 2'h2;

	typedef enum {
		ST_START,
		ST_LOAD,
		ST_LOW,
		ST_HIGH,
		ST_DECIDE,
		ST_RUN
	} sscr_state_t;

	// Three-stage pin filter: the value moves only when stages two and three agree.
	function automatic logic pin_filter(input logic prev, input logic s2, input logic s3);
		pin_filter = (s2 == s3) ? s3 : prev;
	endfunction

	function automatic logic [KBPS_W-1:0] rate_kbps(input logic [RATE_W-1:0] code);
		unique case (code)
			3'h0: rate_kbps = 10'h00A;
			3'h1: rate_kbps = 10'h014;
			3'h2: rate_kbps = 10'h032;
			3'h3: rate_kbps = 10'h07D;
			3'h4: rate_kbps = 10'h0FA;
			3'h5: rate_kbps = 10'h1F4;
			3'h6: rate_kbps = 10'h320;
			3'h7: rate_kbps = 10'h3E8;
		endcase
	endfunction

	// Frame length per converter type; an unknown type falls back to the long frame.
	function automatic logic [FLEN_W-1:0] frame_len(input logic [1:0] kind);
		frame_len = (kind == CONV_TYPE_A || kind == CONV_TYPE_C) ? FLEN_SHORT : FLEN_LONG;
	endfunction

endpackage

// *** sscr_spi_master.sv ***
// Mode-0 serial master for an external converter link.
module sscr_spi_master #(
	parameter int HALF_CYC = sscr_pkg::SPI_HALF_CYC,
	parameter int W = sscr_pkg::SPI_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// User side
	input wire logic start,
	input wire logic [W-1:0] tx_word,
	input wire logic [sscr_pkg::FLEN_W-1:0] flen,
	input wire logic ignore_miso,
	output logic busy,
	output logic done,
	output logic [W-1:0] rx_word,
	// Pins
	output logic select_n,
	output logic sclk,
	output logic mosi,
	input wire logic miso
);
	import sscr_pkg::*;

	logic [DIV_W-1:0] div_r;
	logic tick;
	logic [W-1:0] tx_r;
	logic [FLEN_W-1:0] bits_r;
	logic m1_r, m2_r, m3_r, miso_f_r;

	// ----------------------------------------------------------------
	// Bit-rate divider and input filter
	// ----------------------------------------------------------------
	assign tick = busy && (div_r == DIV_W'(HALF_CYC - 1));

	always_ff @(posedge core_clk) begin
		if (rst || !busy || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			m1_r <= 1'b0;
			m2_r <= 1'b0;
			m3_r <= 1'b0;
			miso_f_r <= 1'b0;
		end else begin
			m1_r <= miso;
			m2_r <= m1_r;
			m3_r <= m2_r;
			miso_f_r <= pin_filter(miso_f_r, m2_r, m3_r);
		end
	end

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			select_n <= 1'b1;
			sclk <= 1'b0;
			mosi <= 1'b0;
			tx_r <= '0;
			rx_word <= '0;
			bits_r <= '0;
		end else begin
			done <= 1'b0;
			if (!busy && start) begin
				busy <= 1'b1;
				select_n <= 1'b0;
				tx_r <= tx_word;
				mosi <= tx_word[W-1];
				rx_word <= '0;
				bits_r <= '0;
			end else if (tick && !sclk) begin
				sclk <= 1'b1;
				rx_word <= {rx_word[W-2:0], miso_f_r & ~ignore_miso};
				bits_r <= bits_r + 1'b1;
			end else if (tick) begin
				sclk <= 1'b0;
				if (bits_r == flen) begin
					busy <= 1'b0;
					done <= 1'b1;
					select_n <= 1'b1;
				end else begin
					tx_r <= tx_r << 1;
					mosi <= tx_r[W-2];
				end
			end
		end
	end

	a_spi_select: assert property (@(posedge core_clk) disable iff (rst)
		busy |-> !select_n) else $error("select released during a frame");
	a_spi_done: assert property (@(posedge core_clk) disable iff (rst)
		done |-> select_n && !sclk && $past(busy)) else $error("done without a frame");

endmodule

// *** sscr_top.sv ***
// Start-up configuration reader with status LED reuse and converter links.
module sscr_top #(
	parameter int SHIFT_HALF = sscr_pkg::SHIFT_HALF_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Configuration register pins
	output logic cfg_shift_clock_green_led,
	output logic cfg_load_n_red_led,
	input wire logic cfg_serial_in,
	output logic cfg_serial_pulldown_en,
	// LED requests and stored settings
	input wire logic green_led_on,
	input wire logic red_led_on,
	input wire logic [sscr_pkg::NODE_W-1:0] stored_node_id,
	input wire logic [sscr_pkg::RATE_W-1:0] stored_rate_code,
	// Configuration result
	output logic cfg_done,
	output logic use_stored,
	output logic recovery_mode,
	output logic [sscr_pkg::NODE_W-1:0] node_id,
	output logic [sscr_pkg::RATE_W-1:0] rate_code,
	output logic [sscr_pkg::KBPS_W-1:0] bit_rate_kbps,
	// ADC link
	input wire logic [1:0] adc_type,
	input wire logic adc_start,
	input wire logic [sscr_pkg::SPI_W-1:0] adc_tx,
	output logic adc_busy,
	output logic adc_done,
	output logic [sscr_pkg::SPI_W-1:0] adc_rx,
	output logic adc_select_n,
	output logic adc_serial_clock,
	output logic adc_data_out,
	input wire logic adc_data_in,
	// DAC link
	input wire logic [1:0] dac_type,
	input wire logic dac_start,
	input wire logic [sscr_pkg::SPI_W-1:0] dac_tx,
	output logic dac_busy,
	output logic dac_done,
	output logic [sscr_pkg::SPI_W-1:0] dac_rx,
	output logic dac_select_n,
	output logic dac_serial_clock,
	output logic dac_data_out,
	input wire logic dac_data_in
);
	import sscr_pkg::*;

	sscr_state_t state_r;
	logic [DIV_W-1:0] div_r;
	logic tick;
	logic [3:0] bits_r;
	logic [CFG_WORD_W-1:0] word_r;
	logic d1_r, d2_r, d3_r, din_f_r;
	logic [DIV_W-1:0] low_run_r;
	logic [3:0] edge_cnt_r;
	logic load_seen_r;
	logic dac_ignore;

	// ----------------------------------------------------------------
	// Shift clock divider and input filter
	// ----------------------------------------------------------------
	assign tick = (div_r == DIV_W'(SHIFT_HALF - 1));

	always_ff @(posedge core_clk) begin
		if (rst || tick || state_r == ST_RUN) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// The pull-down makes an absent register read as zeros, which lands on the fallback.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_serial_pulldown_en <= 1'b0;
			d1_r <= 1'b0;
			d2_r <= 1'b0;
			d3_r <= 1'b0;
			din_f_r <= 1'b0;
		end else begin
			cfg_serial_pulldown_en <= 1'b1;
			d1_r <= cfg_serial_in;
			d2_r <= d1_r;
			d3_r <= d2_r;
			din_f_r <= pin_filter(din_f_r, d2_r, d3_r);
		end
	end

	// ----------------------------------------------------------------
	// Read sequence
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= ST_START;
			bits_r <= '0;
			word_r <= '0;
		end else begin
			unique case (state_r)
				ST_START: if (tick) state_r <= ST_LOAD;
				ST_LOAD: if (tick) state_r <= ST_LOW;
				ST_LOW: begin
					if (tick) begin
						word_r <= {word_r[CFG_WORD_W-2:0], din_f_r};
						bits_r <= bits_r + 1'b1;
						state_r <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (tick) begin
						state_r <= (bits_r == BIT_CNT_W) ? ST_DECIDE : ST_LOW;
					end
				end
				ST_DECIDE: state_r <= ST_RUN;
				ST_RUN: state_r <= ST_RUN;
			endcase
		end
	end

	// Pin drive: shift duties during the read, LED duties afterwards.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_shift_clock_green_led <= 1'b0;
			cfg_load_n_red_led <= 1'b1;
		end else if (state_r == ST_RUN) begin
			cfg_shift_clock_green_led <= green_led_on;
			cfg_load_n_red_led <= red_led_on;
		end else begin
			cfg_load_n_red_led <= !(state_r == ST_START && tick) && !(state_r == ST_LOAD && !tick);
			cfg_shift_clock_green_led <= (state_r == ST_LOW && tick) || (state_r == ST_HIGH && !tick);
		end
	end

	// ----------------------------------------------------------------
	// Decision
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_done <= 1'b0;
			use_stored <= 1'b0;
			recovery_mode <= 1'b0;
			node_id <= '0;
			rate_code <= '0;
			bit_rate_kbps <= '0;
		end else if (state_r == ST_DECIDE) begin
			cfg_done <= 1'b1;
			if (word_r == WORD_RECOVERY) begin
				recovery_mode <= 1'b1;
				node_id <= stored_node_id;
				rate_code <= stored_rate_code;
				bit_rate_kbps <= rate_kbps(stored_rate_code);
			end else if (word_r[NODE_MSB:NODE_LSB] == NODE_ILLEGAL) begin
				use_stored <= 1'b1;
				node_id <= stored_node_id;
				rate_code <= stored_rate_code;
				bit_rate_kbps <= rate_kbps(stored_rate_code);
			end else begin
				node_id <= word_r[NODE_MSB:NODE_LSB];
				rate_code <= word_r[RATE_MSB:RATE_LSB];
				bit_rate_kbps <= rate_kbps(word_r[RATE_MSB:RATE_LSB]);
			end
		end
	end

	// ----------------------------------------------------------------
	// Converter links
	// ----------------------------------------------------------------
	assign dac_ignore = (dac_type == CONV_TYPE_A) || (dac_type == CONV_TYPE_B);

	sscr_spi_master #(.HALF_CYC(SPI_HALF_CYC), .W(SPI_W)) u_adc (
		.core_clk(core_clk),
		.rst(rst),
		.start(adc_start),
		.tx_word(adc_tx),
		.flen(frame_len(adc_type)),
		.ignore_miso(1'b0),
		.busy(adc_busy),
		.done(adc_done),
		.rx_word(adc_rx),
		.select_n(adc_select_n),
		.sclk(adc_serial_clock),
		.mosi(adc_data_out),
		.miso(adc_data_in)
	);

	sscr_spi_master #(.HALF_CYC(SPI_HALF_CYC), .W(SPI_W)) u_dac (
		.core_clk(core_clk),
		.rst(rst),
		.start(dac_start),
		.tx_word(dac_tx),
		.flen(frame_len(dac_type)),
		.ignore_miso(dac_ignore),
		.busy(dac_busy),
		.done(dac_done),
		.rx_word(dac_rx),
		.select_n(dac_select_n),
		.sclk(dac_serial_clock),
		.mosi(dac_data_out),
		.miso(dac_data_in)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			low_run_r <= '0;
			edge_cnt_r <= '0;
			load_seen_r <= 1'b0;
		end else begin
			low_run_r <= cfg_shift_clock_green_led ? '0 : low_run_r + 1'b1;
			if (!cfg_done && !cfg_load_n_red_led) begin
				load_seen_r <= 1'b1;
			end
			if (!cfg_done && cfg_shift_clock_green_led && low_run_r != '0) begin
				edge_cnt_r <= edge_cnt_r + 1'b1;
			end
		end
	end

	// Load must stay low for several cycles so the register sees a clean capture.
	sequence s_load_low;
		!cfg_load_n_red_led [*8];
	endsequence

	a_clk_low_time: assert property (@(posedge core_clk) disable iff (rst)
		($rose(cfg_shift_clock_green_led) && !cfg_done) |-> low_run_r >= SHIFT_HALF)
		else $error("shift clock low phase too short");
	a_load_first: assert property (@(posedge core_clk) disable iff (rst)
		($rose(cfg_shift_clock_green_led) && !cfg_done) |-> load_seen_r && cfg_load_n_red_led)
		else $error("clock edge before load pulse");
	a_load_width: assert property (@(posedge core_clk) disable iff (rst)
		($fell(cfg_load_n_red_led) && !cfg_done) |-> s_load_low)
		else $error("load pulse too short");
	a_ten_edges: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == ST_DECIDE) |-> edge_cnt_r == BIT_CNT_W)
		else $error("wrong number of shift edges");
	a_word_fields: assert property (@(posedge core_clk) disable iff (rst)
		($rose(cfg_done) && !use_stored && !recovery_mode)
		|-> node_id == word_r[NODE_MSB:NODE_LSB] && rate_code == word_r[RATE_MSB:RATE_LSB])
		else $error("fields taken from wrong bits");
	a_fallback_sel: assert property (@(posedge core_clk) disable iff (rst)
		$rose(cfg_done) |-> use_stored == (word_r[NODE_MSB:NODE_LSB] == NODE_ILLEGAL))
		else $error("fallback chosen wrongly");
	a_recovery_word: assert property (@(posedge core_clk) disable iff (rst)
		$rose(cfg_done) |-> recovery_mode == (word_r == WORD_RECOVERY))
		else $error("recovery mode chosen wrongly");
	a_rate_decode: assert property (@(posedge core_clk) disable iff (rst)
		cfg_done |-> bit_rate_kbps == rate_kbps(rate_code))
		else $error("bit rate decode wrong");
	a_led_reuse: assert property (@(posedge core_clk) disable iff (rst)
		cfg_done ##1 cfg_done |-> cfg_shift_clock_green_led == $past(green_led_on)
		&& cfg_load_n_red_led == $past(red_led_on))
		else $error("LED pins not following requests");
	a_pulldown_on: assert property (@(posedge core_clk) disable iff (rst)
		$past(!rst) |-> cfg_serial_pulldown_en)
		else $error("pull-down not enabled");
	a_dac_ignore: assert property (@(posedge core_clk) disable iff (rst)
		(dac_done && dac_ignore) |-> dac_rx == '0)
		else $error("unused DAC input was read");

endmodule

// *** sscr_shreg_model.sv ***
// Behavioural parallel-load serial-out register with its switch bank.
module sscr_shreg_model (
	// Register pins
	input wire logic shift_clk,
	input wire logic load_n,
	input wire logic pd_en,
	output logic ser_out,
	// Switch bank and fitting
	input wire logic [9:0] switches,
	input wire logic fitted
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [9:0] sr_r = 10'h000;

	// Capture and shift share one process so the word has a single driver.
	// The switches are only changed while the reader is in reset, so capturing
	// on the falling load edge behaves like the level-sensitive part.
	// The serial input of the chain is grounded, so zeros follow the word.
	always @(posedge shift_clk or negedge load_n) begin
		if (!load_n) begin
			sr_r <= switches;
		end else begin
			sr_r <= {sr_r[8:0], 1'b0};
		end
	end

	// With no register fitted only the pull-down decides the level.
	assign ser_out = fitted ? sr_r[9] : ~pd_en;
endmodule

// *** sscr_top_tb.sv ***
// Self-checking bench of the start-up configuration reader.
module sscr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sscr_pkg::*;
	// 16 cycles a phase gives a 160 ns shift clock period.
	localparam int HALF = 16;
	localparam logic [9:0] KB [8] = '{10'h00A, 10'h014, 10'h032, 10'h07D,
		10'h0FA, 10'h1F4, 10'h320, 10'h3E8};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic grn = 1'b0;
	logic red = 1'b0;
	logic [1:0] a_ty = 2'h0;
	logic [1:0] d_ty = 2'h0;
	logic a_go = 1'b0;
	logic d_go = 1'b0;
	logic [23:0] tx = 24'hC3A55A;
	logic [9:0] sw = 10'h000;
	logic fit = 1'b1;
	logic sck_p, ld_p, ser, pd, done, st, rec;
	logic [6:0] nd;
	logic [2:0] rc;
	logic [9:0] kb;
	logic a_bsy, a_dn, a_cs, a_sck, a_mo, d_bsy, d_dn, d_cs, d_sck, d_mo;
	logic [23:0] a_rx, d_rx;
	logic sck_q, ld_q;
	int err_count = 0;
	int n_compared = 0;
	int rises, loads, shorts, ph;

	// ----------------------------------------------------------------
	// Design, partner and converter stand-ins
	// ----------------------------------------------------------------
	sscr_top #(.SHIFT_HALF(HALF)) u_dut (.core_clk(core_clk), .rst(rst),
		.cfg_shift_clock_green_led(sck_p), .cfg_load_n_red_led(ld_p),
		.cfg_serial_in(ser), .cfg_serial_pulldown_en(pd), .green_led_on(grn),
		.red_led_on(red), .stored_node_id(7'h2A), .stored_rate_code(3'h6),
		.cfg_done(done), .use_stored(st), .recovery_mode(rec), .node_id(nd),
		.rate_code(rc), .bit_rate_kbps(kb), .adc_type(a_ty), .adc_start(a_go),
		.adc_tx(tx), .adc_busy(a_bsy), .adc_done(a_dn), .adc_rx(a_rx),
		.adc_select_n(a_cs), .adc_serial_clock(a_sck), .adc_data_out(a_mo),
		.adc_data_in(a_cs ? ~a_mo : a_mo), .dac_type(d_ty), .dac_start(d_go),
		.dac_tx(tx), .dac_busy(d_bsy), .dac_done(d_dn), .dac_rx(d_rx),
		.dac_select_n(d_cs), .dac_serial_clock(d_sck), .dac_data_out(d_mo),
		.dac_data_in(d_cs ? ~d_mo : d_mo));
	sscr_shreg_model u_sr (.shift_clk(sck_p), .load_n(ld_p), .pd_en(pd),
		.ser_out(ser), .switches(sw), .fitted(fit));

	initial forever #2.5 core_clk = ~core_clk;

	// Shift clock edges, load pulses and phases shorter than allowed.
	always @(posedge core_clk) begin
		sck_q <= sck_p;
		ld_q <= ld_p;
		if (rst) begin
			rises <= 0;
			loads <= 0;
			shorts <= 0;
			ph <= 0;
		end else if (!done) begin
			ph <= (sck_p != sck_q) ? 1 : ph + 1;
			if (sck_p && !sck_q) rises <= rises + 1;
			if (!ld_p && ld_q) loads <= loads + 1;
			if (sck_p != sck_q && ph > 0 && ph < HALF) shorts <= shorts + 1;
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Reset with a given switch word, then wait for the read to finish.
	task automatic boot(input logic [9:0] w, input logic f);
		int n;
		@(negedge core_clk);
		sw = w;
		fit = f;
		rst = 1'b1;
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(negedge core_clk);
			n++;
		end
		chk(24'(done), 24'h1, "done");
		chk(24'(rises), 24'd10, "edges");
		chk(24'(loads), 24'd1, "loads");
		chk(24'(shorts), 24'd0, "short phase");
		chk(24'(pd), 24'h1, "pulldown");
	endtask

	task automatic expect_cfg(input logic s, input logic r, input logic [6:0] n,
		input logic [2:0] c);
		chk(24'(st), 24'(s), "stored");
		chk(24'(rec), 24'(r), "recovery");
		chk(24'(nd), 24'(n), "node");
		chk(24'(rc), 24'(c), "rate");
		chk(24'(kb), 24'(KB[c]), "kbps");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_rates();
		for (int r = 0; r < 8; r++) begin
			// The node field never reaches zero here, so no pass falls back.
			boot({7'(8'hD5 >> r), 3'(r)}, 1'b1);
			expect_cfg(1'b0, 1'b0, 7'(8'hD5 >> r), 3'(r));
		end
		$display("test rates done");
	endtask

	task automatic t_fallback();
		boot(10'h007, 1'b1);
		expect_cfg(1'b1, 1'b0, 7'h2A, 3'h6);
		boot(10'h3FF, 1'b0);
		expect_cfg(1'b1, 1'b0, 7'h2A, 3'h6);
		boot(10'h3FF, 1'b1);
		expect_cfg(1'b0, 1'b1, 7'h2A, 3'h6);
		boot(10'h3FE, 1'b1);
		expect_cfg(1'b0, 1'b0, 7'h7F, 3'h6);
		$display("test fallback done");
	endtask

	task automatic t_leds();
		for (int i = 0; i < 2; i++) begin
			grn = i[0];
			red = ~i[0];
			repeat (3) @(negedge core_clk);
			chk(24'(sck_p), 24'(i), "green");
			chk(24'(ld_p), 24'(1 - i), "red");
		end
		$display("test leds done");
	endtask

	task automatic t_spi();
		logic sa, sd;
		int n;
		for (int k = 0; k < 3; k++) begin
			a_ty = 2'(k);
			d_ty = 2'(k);
			a_go = 1'b1;
			d_go = 1'b1;
			@(negedge core_clk);
			a_go = 1'b0;
			d_go = 1'b0;
			@(negedge core_clk);
			chk({22'h0, a_bsy, d_bsy}, 24'h3, "busy");
			sa = 1'b0;
			sd = 1'b0;
			n = 0;
			while (!(sa && sd) && n < 6000) begin
				@(negedge core_clk);
				sa = sa | (a_dn === 1'b1);
				sd = sd | (d_dn === 1'b1);
				n++;
			end
			chk({22'h0, sa, sd}, 24'h3, "spi done");
			chk({20'h0, a_cs, d_cs, a_sck, d_sck}, 24'hC, "idle pins");
			chk(a_rx, (k == 1) ? tx : {8'h00, tx[23:8]}, "adc rx");
			chk(d_rx, (k == 2) ? {8'h00, tx[23:8]} : 24'h0, "dac rx");
		end
		$display("test spi done");
	endtask

	initial begin
		t_rates();
		t_fallback();
		t_leds();
		t_spi();
		end_sim();
	end

	initial begin
		#400us;
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim();
	end
endmodule
